// [hdl/dead_time_gate.sv]
// delays the active-going edge of one channel by a programmable count
`timescale 1ns/100ps
`default_nettype none
module dead_time_gate #(
  parameter int unsigned CNT_W = 6
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             en,
  input  wire logic [CNT_W-1:0] dt_cnt,
  // channel activity
  input  wire logic             act_in,
  output logic                  act_q
);

  logic [CNT_W-1:0] cnt_q;

  // counts cycles the input has been active
  always_ff @(posedge clk) begin
    if (!rst_n || !act_in) begin
      cnt_q <= '0;
    end else if (cnt_q != dt_cnt) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // inactive edge passes at once, active edge waits out the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act_q <= 1'b0;
    end else if (!en || !act_in) begin
      act_q <= act_in;
    end else if (cnt_q == dt_cnt) begin
      act_q <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// [hdl/mask_buffer.sv]
// double-buffered channel output mask
`timescale 1ns/100ps
`default_nettype none
module mask_buffer
  import tomp_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_CHAN
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // software side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             sync_sel,
  input  wire logic             pwm_sync,
  // mask values
  output logic      [WIDTH-1:0] buf_q,
  output logic      [WIDTH-1:0] active_q
);

  // write buffer, never the active mask directly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_q <= WIDTH'(RST_MASK);
    end else if (wr_en) begin
      buf_q <= wdata;
    end
  end

  // active mask load point
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_q <= WIDTH'(RST_MASK);
    end else if (!sync_sel || pwm_sync) begin
      active_q <= buf_q;
    end
  end

endmodule
`default_nettype wire

// [hdl/timer_output_mask_pair_ctrl.sv]
// channel output masking and linked channel pair controls with register port
`timescale 1ns/100ps
`default_nettype none
module timer_output_mask_pair_ctrl
  import tomp_pkg::*;
#(
  parameter int unsigned DT_W = DT_CNT_W
) (
  // clock and reset
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RESET_N,
  // register port
  input  wire logic [ADDR_W-1:0]   I_ADDR,
  input  wire logic [DATA_W-1:0]   I_WDATA,
  input  wire logic                I_WR,
  input  wire logic                I_RD,
  output logic      [DATA_W-1:0]   O_RDATA,
  // channel mode side
  input  wire logic [NUM_CHAN-1:0] I_MATCH,
  input  wire logic [NUM_CHAN-1:0] I_MATCH_LVL,
  input  wire logic [NUM_CHAN-1:0] I_INACTIVE_LVL,
  input  wire logic                I_PWM_SYNC,
  // fault pin
  input  wire logic                I_FAULT_PIN,
  // channel outputs and pair controls
  output logic      [NUM_CHAN-1:0]  O_CHAN,
  output logic      [NUM_PAIRS-1:0] O_CV_SYNC_EN,
  output logic      [NUM_PAIRS-1:0] O_FAULT_EN
);

  reg_req_t                  req;
  logic                      wr_mask;
  logic                      wr_pair;
  logic                      wr_ctrl;
  logic [NUM_CHAN-1:0]       mask_buf;
  logic [NUM_CHAN-1:0]       mask_act;
  pair_cfg_t [NUM_PAIRS-1:0] pair_q;
  logic                      wp_dis_q;
  logic                      msync_q;
  logic [DT_W-1:0]           dt_cnt_q;
  logic                      fault_m_q;
  logic                      fault_s_q;
  logic [NUM_CHAN-1:0]       mode_q;
  logic [NUM_CHAN-1:0]       act_d;
  logic [NUM_CHAN-1:0]       act_dt;
  logic [NUM_CHAN-1:0]       chan_q;
  logic [DATA_W-1:0]         rdata_d;
  logic [DATA_W-1:0]         rdata_q;

  // bundle the register port
  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // write decode
  assign wr_mask = req.wr && (req.addr == OFS_OUTPUT_MASK);
  assign wr_pair = req.wr && (req.addr == OFS_LINKED_FUNC);
  assign wr_ctrl = req.wr && (req.addr == OFS_MODE_CTRL);

  // buffered mask, only bits 7..0 kept
  mask_buffer #(
    .WIDTH    (NUM_CHAN)
  ) u_mask (
    .clk      (I_REF_CLK),
    .rst_n    (I_RESET_N),
    .wr_en    (wr_mask),
    .wdata    (req.wdata[NUM_CHAN-1:0]),
    .sync_sel (msync_q),
    .pwm_sync (I_PWM_SYNC),
    .buf_q    (mask_buf),
    .active_q (mask_act)
  );

  // mode control register
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      wp_dis_q <= RST_WP_DIS;
      msync_q  <= RST_MSYNC;
      dt_cnt_q <= DT_W'(RST_DT_CNT);
    end else if (wr_ctrl) begin
      wp_dis_q <= req.wdata[WP_DIS_POS];
      msync_q  <= req.wdata[MASK_SYNC_POS];
      dt_cnt_q <= req.wdata[DT_CNT_LSB +: DT_W];
    end
  end

  // linked function fields, one set per channel pair
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        pair_q[p] <= '0;
      end else if (wr_pair) begin
        pair_q[p].sync_en <= req.wdata[pair_bit_idx(p, SYNC_EN_POS)];
        if (wp_dis_q) begin
          pair_q[p].fault_en <= req.wdata[pair_bit_idx(p, FAULT_EN_POS)];
          pair_q[p].dt_en    <= req.wdata[pair_bit_idx(p, DT_EN_POS)];
        end
      end
    end

    // pair controls toward compare and fault logic
    assign O_CV_SYNC_EN[p] = pair_q[p].sync_en;
    assign O_FAULT_EN[p]   = pair_q[p].fault_en;
  end

  // fault pin synchroniser
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      fault_m_q <= 1'b0;
      fault_s_q <= 1'b0;
    end else begin
      fault_m_q <= I_FAULT_PIN;
      fault_s_q <= fault_m_q;
    end
  end

  // channel mode level, responds to a match only when unmasked
  // starts at the inactive level so no channel comes out of reset active
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      mode_q <= I_INACTIVE_LVL;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (mask_act[i]) begin
          mode_q[i] <= I_INACTIVE_LVL[i];
        end else if (I_MATCH[i]) begin
          mode_q[i] <= I_MATCH_LVL[i];
        end
      end
    end
  end

  // channel activity after mask and fault forcing
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      act_d[i] = (mode_q[i] != I_INACTIVE_LVL[i]) && !mask_act[i];
      if (pair_q[i / 2].fault_en && fault_s_q) begin
        act_d[i] = 1'b0;
      end
    end
  end

  // deadtime on the active-going edge of each channel of an enabled pair
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_dt
    dead_time_gate #(
      .CNT_W  (DT_W)
    ) u_dt (
      .clk    (I_REF_CLK),
      .rst_n  (I_RESET_N),
      .en     (pair_q[c / 2].dt_en),
      .dt_cnt (dt_cnt_q),
      .act_in (act_d[c]),
      .act_q  (act_dt[c])
    );
  end

  // output pins, all zero in reset, then inactive level unless active after deadtime
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      chan_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_q[i] <= (act_dt[i] && !mask_act[i]) ? ~I_INACTIVE_LVL[i] : I_INACTIVE_LVL[i];
      end
    end
  end

  assign O_CHAN = chan_q;

  // read mux, reserved and unmapped bits read zero
  always_comb begin
    rdata_d = '0;
    case (req.addr)
      OFS_OUTPUT_MASK: begin
        rdata_d[NUM_CHAN-1:0] = mask_buf;
      end
      OFS_LINKED_FUNC: begin
        for (int p = 0; p < NUM_PAIRS; p++) begin
          rdata_d[pair_bit_idx(p, FAULT_EN_POS)] = pair_q[p].fault_en;
          rdata_d[pair_bit_idx(p, SYNC_EN_POS)]  = pair_q[p].sync_en;
          rdata_d[pair_bit_idx(p, DT_EN_POS)]    = pair_q[p].dt_en;
        end
      end
      OFS_MODE_CTRL: begin
        rdata_d[WP_DIS_POS]              = wp_dis_q;
        rdata_d[MASK_SYNC_POS]           = msync_q;
        rdata_d[DT_CNT_LSB +: DT_W]      = dt_cnt_q;
      end
      OFS_STATUS: begin
        rdata_d[STAT_MASK_LSB +: NUM_CHAN] = mask_act;
        rdata_d[STAT_FAULT_POS]            = fault_s_q;
        rdata_d[STAT_CHAN_LSB +: NUM_CHAN] = chan_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      rdata_q <= '0;
    end else if (req.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign O_RDATA = rdata_q;

endmodule
`default_nettype wire

// [shared/tomp_pkg.sv]
// constants, field layouts and carrier types for the output mask and pair function block
// Summary of operation
// - mask writes go to a write buffer
// - buffer copied to active mask on sync
// - select 0 loads every clock, 1 on sync
// - mask bits 7..0 map channels 7..0
// - active mask gates response to compare match
// - masked channel forced to inactive state
// - unmasked channel follows its channel mode
// - reserved bits read zero, writes ignored
// - channels grouped in pairs n, n+1 (n=0,2,4,6)
// - bit 30 enables fault control, pair 6
// - bit 29 enables value sync, pair 6
// - bit 28 enables deadtime, pair 6
// - protected fields writable only when unprotected
package tomp_pkg;

  // geometry
  localparam int unsigned NUM_CHAN   = 8;
  localparam int unsigned NUM_PAIRS  = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // register byte offsets
  localparam logic [7:0] OFS_OUTPUT_MASK = 8'h00;
  localparam logic [7:0] OFS_LINKED_FUNC = 8'h04;
  localparam logic [7:0] OFS_MODE_CTRL   = 8'h08;
  localparam logic [7:0] OFS_STATUS      = 8'h0C;

  // linked function fields, one byte per pair
  localparam int unsigned PAIR_STRIDE  = 8;
  localparam int unsigned FAULT_EN_POS = 6;
  localparam int unsigned SYNC_EN_POS  = 5;
  localparam int unsigned DT_EN_POS    = 4;

  // mode control fields
  localparam int unsigned WP_DIS_POS     = 0;
  localparam int unsigned MASK_SYNC_POS  = 1;
  localparam int unsigned DT_CNT_LSB     = 8;
  localparam int unsigned DT_CNT_W       = 6;

  // status fields
  localparam int unsigned STAT_MASK_LSB  = 0;
  localparam int unsigned STAT_FAULT_POS = 8;
  localparam int unsigned STAT_CHAN_LSB  = 16;

  // reset values
  localparam logic [7:0]          RST_MASK   = 8'h00;
  localparam logic                RST_WP_DIS = 1'b0;
  localparam logic                RST_MSYNC  = 1'b0;
  localparam logic [DT_CNT_W-1:0] RST_DT_CNT = 6'h00;

  // one register access from software
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // per-pair linked channel controls
  typedef struct packed {
    logic fault_en;
    logic sync_en;
    logic dt_en;
  } pair_cfg_t;

  // bit index of a pair field inside the linked function register
  function automatic int unsigned pair_bit_idx(input int unsigned pair, input int unsigned pos);
    pair_bit_idx = pair * PAIR_STRIDE + pos;
  endfunction

endpackage

// [sim/power_stage_model.sv]
// power stage model reporting a trip on its fault line
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
  // clock and trip request
  input  wire logic clk,
  input  wire logic trip,
  // fault line to the block
  output logic      fault = 1'b0
);
  // fault line follows a trip one cycle later
  always_ff @(posedge clk) begin
    fault <= trip;
  end
endmodule
`default_nettype wire

// [sim/tb_timer_output_mask_pair_ctrl.sv]
// self-checking bench for the output mask and pair control block
`timescale 1ns/100ps
`default_nettype none
module tb_timer_output_mask_pair_ctrl;
  import tomp_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, psync = 1'b0, trip = 1'b0, fault;
  logic [7:0]  addr = 8'h00, match = 8'h00, mlvl = 8'h00, inact = 8'h0F, chan;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [3:0]  cvs, fen;
  int          failures = 0, n_tests = 0;
  // 20 MHz clock
  initial forever #25 clk = ~clk;
  timer_output_mask_pair_ctrl dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_MATCH(match), .I_MATCH_LVL(mlvl), .I_INACTIVE_LVL(inact),
    .I_PWM_SYNC(psync), .I_FAULT_PIN(fault), .O_CHAN(chan), .O_CV_SYNC_EN(cvs), .O_FAULT_EN(fen));
  power_stage_model stage (.clk(clk), .trip(trip), .fault(fault));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask
  task automatic hit(input logic [7:0] lvl);
    @(posedge clk);
    match <= 8'hFF;
    mlvl  <= lvl;
    @(posedge clk);
    match <= 8'h00;
    cycles(4);
  endtask
  task automatic t_reset();
    chk({28'h0, fen}, 32'h0);
    rreg(OFS_OUTPUT_MASK);
    chk(r, 32'h0);
    rreg(8'h10);
    chk(r, 32'h0);
    chk({24'h0, chan}, 32'h0F);
    $display("reset test done");
  endtask
  task automatic t_buffer();
    wreg(OFS_MODE_CTRL, 32'h2);
    wreg(OFS_OUTPUT_MASK, 32'hFFFF_FF81);
    rreg(OFS_OUTPUT_MASK);
    chk(r, 32'h81);
    rreg(OFS_STATUS);
    chk({24'h0, r[7:0]}, 32'h0);
    @(posedge clk);
    psync <= 1'b1;
    @(posedge clk);
    psync <= 1'b0;
    rreg(OFS_STATUS);
    chk({24'h0, r[7:0]}, 32'h81);
    wreg(OFS_MODE_CTRL, 32'h0);
    wreg(OFS_OUTPUT_MASK, 32'h0);
    rreg(OFS_STATUS);
    chk({24'h0, r[7:0]}, 32'h0);
    $display("buffer test done");
  endtask
  task automatic t_outputs();
    hit(8'hF0);
    chk({24'h0, chan}, 32'hF0);
    wreg(OFS_OUTPUT_MASK, 32'h3C);
    cycles(4);
    chk({24'h0, chan}, 32'hCC);
    hit(8'h00);
    chk({24'h0, chan}, 32'h0C);
    wreg(OFS_OUTPUT_MASK, 32'h0);
    cycles(4);
    chk({24'h0, chan}, 32'h0C);
    hit(8'hFF);
    chk({24'h0, chan}, 32'hFF);
    $display("output test done");
  endtask
  task automatic t_protect();
    wreg(OFS_LINKED_FUNC, 32'hFFFF_FFFF);
    rreg(OFS_LINKED_FUNC);
    chk(r, 32'h2020_2020);
    chk({28'h0, cvs}, 32'hF);
    wreg(OFS_MODE_CTRL, 32'h1);
    wreg(OFS_LINKED_FUNC, 32'hFFFF_FFFF);
    rreg(OFS_LINKED_FUNC);
    chk(r, 32'h7070_7070);
    wreg(OFS_LINKED_FUNC, 32'h4040_4040);
    rreg(OFS_LINKED_FUNC);
    chk(r, 32'h4040_4040);
    chk({28'h0, fen}, 32'hF);
    $display("protect test done");
  endtask
  task automatic t_fault();
    hit(8'hF0);
    chk({24'h0, chan}, 32'hF0);
    trip <= 1'b1;
    cycles(6);
    chk({24'h0, chan}, 32'h0F);
    rreg(OFS_STATUS);
    chk(r, 32'h000F_0100);
    wreg(OFS_LINKED_FUNC, 32'h4000_0000);
    cycles(4);
    chk({24'h0, chan}, 32'h30);
    trip <= 1'b0;
    $display("fault test done");
  endtask
  // deadtime of 3 cycles on pair 6 only, pair 4 rises undelayed
  task automatic t_deadtime();
    wreg(OFS_MODE_CTRL, 32'h0000_0301);
    rreg(OFS_MODE_CTRL);
    chk(r, 32'h0000_0301);
    wreg(OFS_LINKED_FUNC, 32'h1000_0000);
    hit(8'h0F);
    chk({24'h0, chan}, 32'h0F);
    @(posedge clk);
    match <= 8'hF0;
    mlvl  <= 8'hF0;
    @(posedge clk);
    match <= 8'h00;
    cycles(4);
    chk({24'h0, chan}, 32'h3F);
    cycles(1);
    chk({24'h0, chan}, 32'hFF);
    rreg(OFS_STATUS);
    chk(r, 32'h00FF_0000);
    $display("deadtime test done");
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_buffer();
    t_outputs();
    t_protect();
    t_fault();
    t_deadtime();
    give_verdict();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire

// [sim/tomp_asserts.sv]
// assertion checker for the output mask and pair control block
`timescale 1ns/100ps
`default_nettype none
module tomp_asserts
  import tomp_pkg::*;
(
  // clock and reset
  input wire logic                 I_REF_CLK,
  input wire logic                 I_RESET_N,
  // register port
  input wire logic [ADDR_W-1:0]    I_ADDR,
  input wire logic [DATA_W-1:0]    I_WDATA,
  input wire logic                 I_WR,
  input wire logic                 I_RD,
  input wire logic [DATA_W-1:0]    O_RDATA,
  // pair controls
  input wire logic [NUM_PAIRS-1:0] O_CV_SYNC_EN,
  input wire logic [NUM_PAIRS-1:0] O_FAULT_EN
);
  logic wp_q;
  logic fw;
  // tracks the write protection disable bit
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) wp_q <= 1'b0;
    else if (I_WR && I_ADDR == OFS_MODE_CTRL) wp_q <= I_WDATA[WP_DIS_POS];
  end
  // write to the linked function register
  assign fw = I_WR && I_ADDR == OFS_LINKED_FUNC;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data not idle zero");
  a_mask_rsvd: assert property (I_RD && I_ADDR == OFS_OUTPUT_MASK |=> O_RDATA[31:8] == 24'h0)
    else $error("mask upper bits not zero");
  a_func_rsvd: assert property (I_RD && I_ADDR == OFS_LINKED_FUNC |=> (O_RDATA & ~32'h70707070) == 32'h0)
    else $error("pair register spare bits not zero");
  a_unmapped_zero: assert property (I_RD && (I_ADDR[1:0] != 2'h0 || I_ADDR > OFS_STATUS) |=> O_RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_sync_write: assert property (fw |=> O_CV_SYNC_EN ==
    {$past(I_WDATA[29]), $past(I_WDATA[21]), $past(I_WDATA[13]), $past(I_WDATA[5])})
    else $error("sync enables not written");
  a_fault_write: assert property (fw && wp_q |=> O_FAULT_EN ==
    {$past(I_WDATA[30]), $past(I_WDATA[22]), $past(I_WDATA[14]), $past(I_WDATA[6])})
    else $error("fault enables not written");
  a_prot_hold: assert property (fw && !wp_q |=> $stable(O_FAULT_EN))
    else $error("protected field changed");
  a_cfg_stable: assert property (!fw |=> $stable(O_FAULT_EN) && $stable(O_CV_SYNC_EN))
    else $error("pair controls changed without write");
endmodule
bind timer_output_mask_pair_ctrl tomp_asserts u_chk (.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_CV_SYNC_EN(O_CV_SYNC_EN), .O_FAULT_EN(O_FAULT_EN));
`default_nettype wire
